// [core/spm_pkg.sv]
`default_nettype none
package spm_pkg;
    // Register indices; byte address is four times the index
    localparam logic [15:0] FUNC_SEL_IDX = 16'h1C00;
    localparam logic [15:0] PULL_ONE_IDX = 16'h1C17;
    localparam logic [15:0] PULL_TWO_IDX = 16'h1C18;
    localparam logic [15:0] PULL_THREE_IDX = 16'h1C19;
    localparam logic [15:0] TAP_SEL_IDX = 16'h1C24;
    localparam logic [15:0] CPU_STAT_IDX = 16'h1C30;

    // Field positions
    localparam int FUNC_SEL_LSB = 0;
    localparam int TAP_SEL_LSB = 0;
    localparam int TAP_GATE_BIT = 2;

    // Reset values
    localparam logic [1:0] FUNC_SEL_RST = 2'h0;
    localparam logic [15:0] PULL_RST = 16'h0000;
    localparam logic [1:0] TAP_SEL_RST = 2'h0;
    localparam logic TAP_GATE_RST = 1'b0;

    // Widths
    localparam int PIN_COUNT = 6;
    localparam int I2S_PINS = 4;
    localparam int TAP_COUNT = 4;

    // Port-0 function codes
    typedef enum logic [1:0] {
        SPM_MODE_SD = 2'b00,
        SPM_MODE_I2S = 2'b01,
        SPM_MODE_GPIO = 2'b10,
        SPM_MODE_RSVD = 2'b11
    } spm_mode_t;

    // Drive of one function or of the pads
    typedef struct packed {
        logic [5:0] out;
        logic [5:0] oe_n;
    } spm_drive_t;
endpackage
`default_nettype wire

// [core/spm_keeper.sv]
`timescale 1ns/10ps
`default_nettype none
module spm_keeper (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control and pad
    input wire logic hold_on_i,
    input wire logic pad_level_i,
    // Holder drive
    output logic hold_en_o,
    output logic hold_level_o
);
    // Holder tracks the pin, so an overdriving source flips it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_level_o <= 1'b0;
        end else begin
            hold_level_o <= pad_level_i;
        end
    end

    // Enable follows absence of core power
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_en_o <= 1'b0;
        end else begin
            hold_en_o <= hold_on_i;
        end
    end
endmodule
`default_nettype wire

// [core/spm_top.sv]
// Summary of operation
// - The two-bit function field routes the six pins to SD on 00, I2S on 01 and GPIO on 10.
// - In I2S mode pins 0 to 3 go to the audio port and pins 4 and 5 stay GPIO bits 4, 5.
// - Each pin has a pull-off bit in pull_inhibit_one that disables its pulldown in any mode.
// - With core power on, holders are off and pulldowns follow their inhibit bits.
// - With core power off and I/O power on, holders are on and all pulldowns are off.
// - An enabled holder keeps the pin's last level and follows an external overdrive.
// - The debug clock pin carries the internal clock chosen by the tap source field.
// - The debug clock pin is held low while the gate-off bit in cpu status is set.
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module spm_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Power state
    input wire logic core_supply_i,
    // Function sides
    input wire spm_pkg::spm_drive_t sd_drive_i,
    input wire spm_pkg::spm_drive_t i2s_drive_i,
    input wire spm_pkg::spm_drive_t gpio_drive_i,
    output logic [5:0] sd_in_o,
    output logic [3:0] i2s_in_o,
    output logic [5:0] gpio_in_o,
    // Pads
    input wire logic [5:0] pad_in_i,
    output var spm_pkg::spm_drive_t pad_drive_o,
    output logic [5:0] internal_pulldown_en_o,
    output logic [5:0] hold_en_o,
    output logic [5:0] hold_level_o,
    // Debug clock tap
    input wire logic [3:0] clk_taps_i,
    output logic debug_clock_tap_pin_o
);
    logic [1:0] port0_function_select_reg;
    logic [15:0] pull_inhibit_one_reg;
    logic [15:0] pull_inhibit_two_reg;
    logic [15:0] pull_inhibit_three_reg;
    logic [1:0] clock_tap_source_field_reg;
    logic clock_tap_gate_off_reg;
    logic [15:0] word_idx;
    logic wr_fire;
    logic [15:0] wr_mask;
    logic [15:0] rd_value;
    spm_pkg::spm_drive_t drive_next;
    logic [5:0] sd_in_next;
    logic [3:0] i2s_in_next;
    logic [5:0] gpio_in_next;

    // Bus decode; a write lands at the edge where the master sees ack
    assign word_idx = {2'h0, wb_adr_i[15:2]};
    assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign wr_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // One-wait-state acknowledge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    // Read multiplexer; unmapped reads zero
    always_comb begin
        rd_value = 16'h0000;
        unique case (word_idx)
            spm_pkg::FUNC_SEL_IDX: begin
                rd_value[spm_pkg::FUNC_SEL_LSB +: 2] = port0_function_select_reg;
            end
            spm_pkg::PULL_ONE_IDX: rd_value = pull_inhibit_one_reg;
            spm_pkg::PULL_TWO_IDX: rd_value = pull_inhibit_two_reg;
            spm_pkg::PULL_THREE_IDX: rd_value = pull_inhibit_three_reg;
            spm_pkg::TAP_SEL_IDX: rd_value[spm_pkg::TAP_SEL_LSB +: 2] = clock_tap_source_field_reg;
            spm_pkg::CPU_STAT_IDX: rd_value[spm_pkg::TAP_GATE_BIT] = clock_tap_gate_off_reg;
            default: rd_value = 16'h0000;
        endcase
    end

    // Registered read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_dat_o <= {16'h0000, rd_value};
        end
    end

    // Function field write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port0_function_select_reg <= spm_pkg::FUNC_SEL_RST;
        end else if (wr_fire && word_idx == spm_pkg::FUNC_SEL_IDX && wb_sel_i[0]) begin
            port0_function_select_reg <= wb_dat_i[spm_pkg::FUNC_SEL_LSB +: 2];
        end
    end

    // Pull inhibit writes, byte lane masked
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pull_inhibit_one_reg <= spm_pkg::PULL_RST;
            pull_inhibit_two_reg <= spm_pkg::PULL_RST;
            pull_inhibit_three_reg <= spm_pkg::PULL_RST;
        end else if (wr_fire) begin
            if (word_idx == spm_pkg::PULL_ONE_IDX) begin
                pull_inhibit_one_reg <= (pull_inhibit_one_reg & ~wr_mask)
                    | (wb_dat_i[15:0] & wr_mask);
            end
            if (word_idx == spm_pkg::PULL_TWO_IDX) begin
                pull_inhibit_two_reg <= (pull_inhibit_two_reg & ~wr_mask)
                    | (wb_dat_i[15:0] & wr_mask);
            end
            if (word_idx == spm_pkg::PULL_THREE_IDX) begin
                pull_inhibit_three_reg <= (pull_inhibit_three_reg & ~wr_mask)
                    | (wb_dat_i[15:0] & wr_mask);
            end
        end
    end

    // Clock tap source and gate writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clock_tap_source_field_reg <= spm_pkg::TAP_SEL_RST;
            clock_tap_gate_off_reg <= spm_pkg::TAP_GATE_RST;
        end else if (wr_fire && wb_sel_i[0]) begin
            if (word_idx == spm_pkg::TAP_SEL_IDX) begin
                clock_tap_source_field_reg <= wb_dat_i[spm_pkg::TAP_SEL_LSB +: 2];
            end
            if (word_idx == spm_pkg::CPU_STAT_IDX) begin
                clock_tap_gate_off_reg <= wb_dat_i[spm_pkg::TAP_GATE_BIT];
            end
        end
    end

    // Pin routing by function field
    always_comb begin
        drive_next.out = 6'h00;
        drive_next.oe_n = 6'h3F;
        sd_in_next = 6'h00;
        i2s_in_next = 4'h0;
        gpio_in_next = 6'h00;
        unique case (spm_pkg::spm_mode_t'(port0_function_select_reg))
            spm_pkg::SPM_MODE_SD: begin
                drive_next = sd_drive_i;
                sd_in_next = pad_in_i;
            end
            spm_pkg::SPM_MODE_I2S: begin
                drive_next.out = {gpio_drive_i.out[5:4], i2s_drive_i.out[3:0]};
                drive_next.oe_n = {gpio_drive_i.oe_n[5:4], i2s_drive_i.oe_n[3:0]};
                i2s_in_next = pad_in_i[3:0];
                gpio_in_next = {pad_in_i[5:4], 4'h0};
            end
            spm_pkg::SPM_MODE_GPIO: begin
                drive_next = gpio_drive_i;
                gpio_in_next = pad_in_i;
            end
            spm_pkg::SPM_MODE_RSVD: begin
                drive_next.out = 6'h00;
                drive_next.oe_n = 6'h3F;
            end
        endcase
        if (!core_supply_i) begin
            drive_next.out = 6'h00;
            drive_next.oe_n = 6'h3F;
        end
    end

    // Registered pad drive and function inputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pad_drive_o <= '{out: 6'h00, oe_n: 6'h3F};
            sd_in_o <= 6'h00;
            i2s_in_o <= 4'h0;
            gpio_in_o <= 6'h00;
        end else begin
            pad_drive_o <= drive_next;
            sd_in_o <= sd_in_next;
            i2s_in_o <= i2s_in_next;
            gpio_in_o <= gpio_in_next;
        end
    end

    // Pulldown enables, forced off without core power
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            internal_pulldown_en_o <= 6'h00;
        end else begin
            internal_pulldown_en_o <= core_supply_i
                ? ~pull_inhibit_one_reg[5:0] : 6'h00;
        end
    end

    // One holder per pin
    genvar g;
    generate
        for (g = 0; g < spm_pkg::PIN_COUNT; g++) begin : gen_keep
            spm_keeper u_keep (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .hold_on_i(!core_supply_i),
                .pad_level_i(pad_in_i[g]),
                .hold_en_o(hold_en_o[g]),
                .hold_level_o(hold_level_o[g])
            );
        end
    endgenerate

    // Debug clock tap selection and gating
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            debug_clock_tap_pin_o <= 1'b0;
        end else begin
            debug_clock_tap_pin_o <= !clock_tap_gate_off_reg
                && clk_taps_i[clock_tap_source_field_reg];
        end
    end

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_sd_route: assert property (port0_function_select_reg == 2'h0 && core_supply_i
        && $stable(port0_function_select_reg) |=> pad_drive_o == $past(sd_drive_i))
        else $error("sd routing wrong");
    chk_gpio_route: assert property (port0_function_select_reg == 2'h2 && core_supply_i
        |=> gpio_in_o == $past(pad_in_i))
        else $error("gpio input routing wrong");
    chk_i2s_split: assert property (port0_function_select_reg == 2'h1 && core_supply_i
        |=> pad_drive_o.out[5:4] == $past(gpio_drive_i.out[5:4])
        && pad_drive_o.out[3:0] == $past(i2s_drive_i.out[3:0]) && sd_in_o == 6'h00)
        else $error("i2s split wrong");
    chk_pull_bits: assert property (core_supply_i
        |=> internal_pulldown_en_o == ~$past(pull_inhibit_one_reg[5:0]))
        else $error("pulldown enable wrong");
    chk_core_on: assert property (core_supply_i [*2] |=> hold_en_o == 6'h00)
        else $error("holder on with core power");
    chk_core_off: assert property (!core_supply_i
        |=> internal_pulldown_en_o == 6'h00 && hold_en_o == 6'h3F
        && pad_drive_o.oe_n == 6'h3F)
        else $error("core off state wrong");
    chk_hold_follow: assert property ($changed(pad_in_i)
        |=> hold_level_o == $past(pad_in_i))
        else $error("holder missed level");
    chk_tap_gate: assert property (clock_tap_gate_off_reg |=> !debug_clock_tap_pin_o)
        else $error("tap not gated");
    chk_tap_src: assert property (!clock_tap_gate_off_reg
        |=> debug_clock_tap_pin_o == $past(clk_taps_i[clock_tap_source_field_reg]))
        else $error("tap source wrong");
    chk_rsvd_mode: assert property (port0_function_select_reg == 2'h3
        |=> pad_drive_o.oe_n == 6'h3F ##0 pad_drive_o.out == 6'h00)
        else $error("reserved mode drives");
    chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held");

    cov_i2s_mode: cover property (port0_function_select_reg == 2'h1 ##1 i2s_in_o != 4'h0);
    cov_power_cycle: cover property ($fell(core_supply_i) ##[1:8] $rose(core_supply_i));
    cov_tap_on: cover property (!clock_tap_gate_off_reg ##1 debug_clock_tap_pin_o);
    cov_rsvd: cover property (port0_function_select_reg == 2'h3);
endmodule
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [15:0] adr = 16'h0000;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic core = 1'b1;
    spm_pkg::spm_drive_t sd_d = {6'h15, 6'h2A};
    spm_pkg::spm_drive_t i2s_d = {6'h3A, 6'h35};
    spm_pkg::spm_drive_t gp_d = {6'h33, 6'h0C};
    spm_pkg::spm_drive_t pad_drive_o;
    logic [5:0] sd_in_o, gpio_in_o, pd_en, hold_en, hold_lvl;
    logic [3:0] i2s_in_o;
    logic [5:0] pad = 6'h2D;
    logic [3:0] taps = 4'h0;
    logic pin;
    int n_mismatch = 0;
    int n_compared = 0;

    // Clock at 100 MHz
    always #5 clk_i = ~clk_i;

    spm_top u_spm_top (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .core_supply_i(core), .sd_drive_i(sd_d),
        .i2s_drive_i(i2s_d), .gpio_drive_i(gp_d), .sd_in_o(sd_in_o), .i2s_in_o(i2s_in_o),
        .gpio_in_o(gpio_in_o), .pad_in_i(pad), .pad_drive_o(pad_drive_o),
        .internal_pulldown_en_o(pd_en), .hold_en_o(hold_en), .hold_level_o(hold_lvl),
        .clk_taps_i(taps), .debug_clock_tap_pin_o(pin)
    );

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: value mismatch, seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // One classic Wishbone cycle; only the watchdog ends a wait for ack
    task automatic wb(input logic w, input logic [15:0] a, input logic [15:0] d,
                      input logic [3:0] s, output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= {16'h0000, d};
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, 4'h3, q);
    endtask

    task automatic rdc(input logic [15:0] a, input logic [15:0] e);
        logic [31:0] q;
        wb(1'b0, a, 16'h0000, 4'h3, q);
        chk(q, {16'h0000, e});
    endtask

    // Function drives in use, or parked idle while their peripherals reset
    task automatic drives(input logic parked);
        sd_d <= parked ? 12'h03F : 12'h56A;
        i2s_d <= parked ? 12'h03F : 12'hEB5;
        gp_d <= parked ? 12'h03F : 12'hCCC;
    endtask

    // Pad drive expected for each function code
    function automatic logic [11:0] exp_pad(input logic [1:0] m);
        case (m)
            2'h0: return sd_d;
            2'h1: return {gp_d.out[5:4], i2s_d.out[3:0], gp_d.oe_n[5:4], i2s_d.oe_n[3:0]};
            2'h2: return gp_d;
            default: return {6'h00, 6'h3F};
        endcase
    endfunction

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watchdog against a hung bus
    initial begin
        step(5000);
        n_mismatch++;
        test_done();
    end

    // Main sequence
    initial begin
        logic [31:0] q;
        step(10);
        rst_i <= 1'b0;
        step(2);
        chk(32'(pd_en), 32'h3F);
        chk(32'(hold_en), 32'h00);
        rdc(16'h7000, 16'h0000);
        rdc(16'h705C, 16'h0000);
        rdc(16'h7090, 16'h0000);
        rdc(16'h70C0, 16'h0000);
        $display("reset test done");
        wr(16'h705C, 16'h0015);
        rdc(16'h705C, 16'h0015);
        wr(16'h7060, 16'hA5A5);
        rdc(16'h7060, 16'hA5A5);
        wr(16'h7064, 16'h5A5A);
        rdc(16'h7064, 16'h5A5A);
        wr(16'h7004, 16'hFFFF);
        rdc(16'h7004, 16'h0000);
        wb(1'b1, 16'h7000, 16'h0002, 4'h2, q);
        rdc(16'h7000, 16'h0000);
        $display("register test done");
        for (int m = 0; m < 4; m++) begin
            wr(16'h7000, 16'(m));
            drives(1'b1);
            step(2);
            chk(32'(pad_drive_o), 32'h03F);
            drives(1'b0);
            step(2);
            rdc(16'h7000, 16'(m));
            chk(32'(pad_drive_o), 32'(exp_pad(2'(m))));
            chk(32'(sd_in_o), (m == 0) ? 32'h2D : 32'h0);
            chk(32'(i2s_in_o), (m == 1) ? 32'hD : 32'h0);
            chk(32'(gpio_in_o), (m == 2) ? 32'h2D : (m == 1) ? 32'h20 : 32'h0);
            chk(32'(pd_en), 32'h2A);
        end
        $display("mode test done");
        for (int i = 0; i < 4; i++) begin
            wr(16'h7090, 16'(i));
            taps <= 4'h1 << i;
            step(2);
            chk(32'(pin), 32'h1);
            taps <= ~(4'h1 << i);
            step(2);
            chk(32'(pin), 32'h0);
        end
        wr(16'h70C0, 16'h0004);
        taps <= 4'hF;
        step(2);
        chk(32'(pin), 32'h0);
        rdc(16'h70C0, 16'h0004);
        wr(16'h70C0, 16'h0000);
        step(2);
        chk(32'(pin), 32'h1);
        $display("clock tap test done");
        wr(16'h7000, 16'h0002);
        core <= 1'b0;
        step(2);
        chk(32'(pad_drive_o), 32'h03F);
        chk(32'(pd_en), 32'h00);
        chk(32'(hold_en), 32'h3F);
        chk(32'(hold_lvl), 32'h2D);
        pad <= 6'h12;
        step(2);
        chk(32'(hold_lvl), 32'h12);
        core <= 1'b1;
        step(2);
        chk(32'(hold_en), 32'h00);
        chk(32'(pd_en), 32'h2A);
        $display("power test done");
        test_done();
    end
endmodule
`default_nettype wire
